// ===== common/host_bus_pkg.sv
// shared types and constants of the host bus request and interrupt block
// assumes a single system clock that is also the host bus clock
package host_bus_pkg;

  // ---------------------------------------------------------------
  // pin group widths and field positions
  // ---------------------------------------------------------------
  localparam int PIN_W = 7;
  localparam int VECTOR_W = 16;
  localparam int BYTE_W = 8;
  localparam int SYNC_DEPTH = 3;

  // inputs coming from the host side, sampled as one group
  typedef struct packed {
    logic holdAckIn;   // first style: high = hold acknowledged
    logic busGrantN;   // second style: low = bus granted
    logic busReleaseN; // low = higher-priority master wants the bus
    logic busBusyN;    // low = bus busy, no takeover
    logic irqAckN;     // low = host acknowledges the interrupt
    logic modeSelect;  // high = first style, low = second style
    logic widthSelect; // first style only: high = 8-bit data path
  } host_pins_t;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  // idle pin levels: pulled-up lines read high, hold acknowledge and width select read low
  localparam host_pins_t PINS_RST = '{
    holdAckIn: 1'b0, busGrantN: 1'b1, busReleaseN: 1'b1, busBusyN: 1'b1,
    irqAckN: 1'b1, modeSelect: 1'b1, widthSelect: 1'b0};
  localparam logic [VECTOR_W-1:0] VECTOR_RST = 16'h0000;
  localparam logic OWNED_IND_RST = 1'b1;

  // ---------------------------------------------------------------
  // arbitration states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ARB_IDLE    = 2'h0, // no request on the bus
    ARB_REQUEST = 2'h1, // request out, waiting for grant and not busy
    ARB_OWN     = 2'h2, // bus owned, dma cycles may run
    ARB_BACKOFF = 2'h3  // request dropped, waiting for grant to go away
  } arb_state_t;

endpackage

// ===== rtl/pin_sync.sv
// three-stage synchroniser for a group of asynchronous pins
// assumes the pins may change at any time relative to sys_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,            // system clock
  input wire logic sys_rst,            // synchronous reset, active high
  input wire logic [WIDTH-1:0] pinIn,  // raw pin levels
  output logic [WIDTH-1:0] pinOut      // filtered, registered levels
);

  logic [WIDTH-1:0] stage1_r, stage2_r, stage3_r, out_r;
  logic [WIDTH-1:0] out_nxt;

  // an empty pin group has nothing to filter
  if (WIDTH < 1) begin : gen_bad_width
    $error("pin group width must be at least 1");
  end

  // ---------------------------------------------------------------
  // filter
  // ---------------------------------------------------------------
  // a bit changes only once stage 2 and stage 3 agree; stage 1 feeds stage 2 only
  always_comb begin
    out_nxt = (stage3_r & ~(stage2_r ^ stage3_r)) | (out_r & (stage2_r ^ stage3_r));
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1_r <= RST_VAL;
      stage2_r <= RST_VAL;
      stage3_r <= RST_VAL;
      out_r <= RST_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      out_r <= out_nxt;
    end
  end

  assign pinOut = out_r;

endmodule
`default_nettype wire

// ===== rtl/host_bus_request_and_interrupt.sv
// bus request, ownership and interrupt handshake toward the host system bus
// assumes sys_clk is the host bus clock and that the dma engine and
// interrupt source sit on the same clock
`timescale 1ns/1ps
`default_nettype none
module host_bus_request_and_interrupt #(
  parameter int VEC_W = host_bus_pkg::VECTOR_W
) (
  input wire logic sys_clk,                 // system and host bus clock
  input wire logic sys_rst,                 // synchronous reset, active high
  input wire logic holdAckIn,               // pin: hold acknowledge, first style
  input wire logic busGrantN,               // pin: bus grant, second style, active low
  input wire logic busReleaseN,             // pin: release request, active low
  input wire logic busBusyN,                // pin: bus busy, active low
  input wire logic irqAckN,                 // pin: interrupt acknowledge, active low
  input wire logic modeSelect,              // pin: high first style, low second
  input wire logic widthSelect,             // pin: high 8-bit path in first style
  input wire logic dmaReq,                  // dma engine has a transfer pending
  input wire logic dmaCycleEnd,             // pulse: current dma bus cycle ends
  input wire logic irqReq,                  // level: interrupt pending
  input wire logic [VEC_W-1:0] irqVector,   // vector to present on acknowledge
  output logic holdRequestOut,              // pin: hold request, active high
  output logic busRequestN,                 // pin: bus request, active low
  output logic irqOutHigh,                  // pin: interrupt, first style
  output logic irqOutLow,                   // pin: interrupt, second style
  output logic busOwnedInd,                 // pin: low while the bus is owned
  output logic [VEC_W-1:0] vectorOut,       // data pins: vector value
  output logic vectorOeN,                   // data pins: low while driving
  output logic dmaGo,                       // dma engine may run bus cycles
  output logic styleFirst,                  // latched bus style, high first
  output logic wide16                       // data path is 16 bits wide
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (VEC_W != 16 && VEC_W != 8) begin : gen_bad_width
    $error("vector width must be 8 or 16");
  end

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  host_bus_pkg::host_pins_t pinsRaw, pins;

  assign pinsRaw = '{holdAckIn: holdAckIn, busGrantN: busGrantN,
                     busReleaseN: busReleaseN, busBusyN: busBusyN, irqAckN: irqAckN,
                     modeSelect: modeSelect, widthSelect: widthSelect};

  pin_sync #(
    .WIDTH(host_bus_pkg::PIN_W),
    .RST_VAL(host_bus_pkg::PINS_RST)
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pinIn(pinsRaw),
    .pinOut(pins)
  );

  // ---------------------------------------------------------------
  // style decode
  // ---------------------------------------------------------------
  // grant seen in the latched style: both polarities handled here only
  function automatic logic granted(input logic first, input host_bus_pkg::host_pins_t p);
    granted = first ? p.holdAckIn : ~p.busGrantN;
  endfunction

  host_bus_pkg::arb_state_t state_r, state_nxt;
  logic style_r, style_nxt;
  logic wide_r, wide_nxt;

  // style and width only move while idle, so a change never cuts a bus tenure
  always_comb begin
    style_nxt = style_r;
    wide_nxt = wide_r;
    if (state_r == host_bus_pkg::ARB_IDLE) begin
      style_nxt = pins.modeSelect;
      wide_nxt = pins.modeSelect ? ~pins.widthSelect : 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      style_r <= 1'b1;
      wide_r <= 1'b1;
    end else begin
      style_r <= style_nxt;
      wide_r <= wide_nxt;
    end
  end

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  logic grantNow;
  logic releaseAsked;

  assign grantNow = granted(style_r, pins);
  // release is only meaningful while dma runs
  assign releaseAsked = ~pins.busReleaseN;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      host_bus_pkg::ARB_IDLE: begin
        if (dmaReq) begin
          state_nxt = host_bus_pkg::ARB_REQUEST;
        end
      end
      host_bus_pkg::ARB_REQUEST: begin
        if (!dmaReq) begin
          state_nxt = host_bus_pkg::ARB_IDLE;
        end else if (grantNow && pins.busBusyN) begin
          state_nxt = host_bus_pkg::ARB_OWN;
        end
      end
      host_bus_pkg::ARB_OWN: begin
        // a cycle in flight always completes before the bus is given up
        if (dmaCycleEnd && (releaseAsked || !dmaReq)) begin
          state_nxt = host_bus_pkg::ARB_BACKOFF;
        end
      end
      host_bus_pkg::ARB_BACKOFF: begin
        // wait for the arbiter to take its grant back before asking again
        if (!grantNow) begin
          state_nxt = dmaReq ? host_bus_pkg::ARB_REQUEST : host_bus_pkg::ARB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= host_bus_pkg::ARB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // request and ownership outputs
  // ---------------------------------------------------------------
  logic holdReq_r, holdReq_nxt;
  logic busReqN_r, busReqN_nxt;
  logic owned_r, owned_nxt;
  logic go_r, go_nxt;
  logic asking;

  // the request stays up through ownership; it drops in backoff
  assign asking = (state_nxt == host_bus_pkg::ARB_REQUEST) || (state_nxt == host_bus_pkg::ARB_OWN);

  always_comb begin
    holdReq_nxt = style_nxt & asking;
    busReqN_nxt = ~(~style_nxt & asking);
    owned_nxt = ~(state_nxt == host_bus_pkg::ARB_OWN);
    go_nxt = (state_nxt == host_bus_pkg::ARB_OWN) && !(dmaCycleEnd && state_r == host_bus_pkg::ARB_OWN
             && (releaseAsked || !dmaReq));
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      holdReq_r <= 1'b0;
      busReqN_r <= 1'b1;
      owned_r <= host_bus_pkg::OWNED_IND_RST;
      go_r <= 1'b0;
    end else begin
      holdReq_r <= holdReq_nxt;
      busReqN_r <= busReqN_nxt;
      owned_r <= owned_nxt;
      go_r <= go_nxt;
    end
  end

  // ---------------------------------------------------------------
  // interrupt request and vector
  // ---------------------------------------------------------------
  logic irqHi_r, irqHi_nxt;
  logic irqLo_r, irqLo_nxt;
  logic [VEC_W-1:0] vec_r, vec_nxt;
  logic vecOeN_r, vecOeN_nxt;

  // the vector pins are shared with the dma data path, so they are
  // only driven while the bus is not owned for dma
  always_comb begin
    // same style as the request pins, so both pin pairs switch on one edge
    irqHi_nxt = style_nxt & irqReq;
    irqLo_nxt = ~(~style_nxt & irqReq);
    // next ownership, so the vector is never out on the edge the bus is taken
    vecOeN_nxt = ~(~pins.irqAckN && owned_nxt);
    vec_nxt = vec_r;
    if (~pins.irqAckN) begin
      vec_nxt = irqVector;
      if (!wide_r) begin
        vec_nxt = '0;
        vec_nxt[host_bus_pkg::BYTE_W-1:0] = irqVector[host_bus_pkg::BYTE_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqHi_r <= 1'b0;
      irqLo_r <= 1'b1;
      vec_r <= host_bus_pkg::VECTOR_RST[VEC_W-1:0];
      vecOeN_r <= 1'b1;
    end else begin
      irqHi_r <= irqHi_nxt;
      irqLo_r <= irqLo_nxt;
      vec_r <= vec_nxt;
      vecOeN_r <= vecOeN_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign holdRequestOut = holdReq_r;
  assign busRequestN = busReqN_r;
  assign busOwnedInd = owned_r;
  assign dmaGo = go_r;
  assign irqOutHigh = irqHi_r;
  assign irqOutLow = irqLo_r;
  assign vectorOut = vec_r;
  assign vectorOeN = vecOeN_r;
  assign styleFirst = style_r;
  assign wide16 = wide_r;

endmodule
`default_nettype wire

// ===== bench/host_bus_sva.sv
// assertion checker for the host bus request and interrupt block
// assumes one clock domain and a bind from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module host_bus_sva (
  input wire logic sys_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic holdAckIn, // pin
  input wire logic busGrantN, // pin
  input wire logic busBusyN, // pin
  input wire logic dmaReq, // engine
  input wire logic dmaCycleEnd, // engine
  input wire logic irqReq, // engine
  input wire logic holdRequestOut, // pin
  input wire logic busRequestN, // pin
  input wire logic irqOutHigh, // pin
  input wire logic irqOutLow, // pin
  input wire logic busOwnedInd, // pin
  input wire logic vectorOeN, // pin
  input wire logic dmaGo, // engine
  input wire logic styleFirst, // latched style
  input wire logic wide16 // path width
);
  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_first_style_pins: assert property (styleFirst |-> busRequestN && irqOutLow)
    else $error("second style pins active in first style");
  a_second_style_pins: assert property (!styleFirst |-> !holdRequestOut && !irqOutHigh && wide16)
    else $error("first style pins active in second style");
  a_dma_with_own: assert property (dmaGo == !busOwnedInd)
    else $error("dma enable and ownership disagree");
  a_own_holds_req: assert property (!busOwnedInd |-> (styleFirst ? holdRequestOut : !busRequestN))
    else $error("bus owned without request");
  a_grant_before_own: assert property ($fell(busOwnedInd) |->
    (styleFirst ? $past(holdAckIn, 3) : !$past(busGrantN, 3)))
    else $error("ownership before grant");
  a_busy_blocks_own: assert property ($fell(busOwnedInd) |-> $past(busBusyN, 3))
    else $error("ownership taken while bus busy");
  a_yield_on_end: assert property (!busOwnedInd && dmaCycleEnd && !dmaReq |=> busOwnedInd && !dmaGo)
    else $error("bus kept after last cycle");
  a_vector_off_bus: assert property (!vectorOeN |-> busOwnedInd)
    else $error("vector driven while owning bus");
  a_irq_high_follows: assert property (styleFirst && $past(styleFirst) |-> irqOutHigh == $past(irqReq))
    else $error("first style interrupt wrong");
  a_irq_low_follows: assert property (!styleFirst && !$past(styleFirst) |-> irqOutLow == !$past(irqReq))
    else $error("second style interrupt wrong");
endmodule
`default_nettype wire

// ===== bench/host_arbiter_model.sv
// host processor and bus arbiter model for the far side
// assumes the bench tells it the bus style through modeSelect
`timescale 1ns/1ps
`default_nettype none
module host_arbiter_model (
  input wire logic sys_clk, // clock
  input wire logic modeSelect, // style chosen by the bench
  input wire logic holdRequestOut, // request, first style
  input wire logic busRequestN, // request, second style
  input wire logic [3:0] grantDelay, // cycles before granting
  output logic holdAckIn, // acknowledge, first style
  output logic busGrantN // grant, second style
);
  logic granted = 1'b0;
  logic [3:0] waitCnt = 4'h0;
  logic req;
  assign req = modeSelect ? holdRequestOut : !busRequestN;
  // grant after the delay; withdraw at once so a yield is seen promptly
  always @(posedge sys_clk) begin
    if (!req) begin
      granted <= 1'b0;
      waitCnt <= 4'h0;
    end else if (waitCnt >= grantDelay) begin
      granted <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
  assign holdAckIn = modeSelect & granted;
  assign busGrantN = !(!modeSelect & granted);
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the host bus request and interrupt block
// assumes the arbiter model answers requests on the far side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic sys_clk = 1'b0, sys_rst = 1'b1, busReleaseN = 1'b1, busBusyN = 1'b1, irqAckN = 1'b1;
  logic modeSelect = 1'b1, widthSelect = 1'b0, dmaReq = 1'b0, dmaCycleEnd = 1'b0, irqReq = 1'b0;
  logic [host_bus_pkg::VECTOR_W-1:0] irqVector = 16'hA5C3, vectorOut;
  logic [3:0] grantDelay = 4'h0;
  logic holdAckIn, busGrantN, holdRequestOut, busRequestN, irqOutHigh, irqOutLow;
  logic busOwnedInd, vectorOeN, dmaGo, styleFirst, wide16;
  int bad_count = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  host_bus_request_and_interrupt dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .holdAckIn(holdAckIn),
    .busGrantN(busGrantN), .busReleaseN(busReleaseN), .busBusyN(busBusyN), .irqAckN(irqAckN),
    .modeSelect(modeSelect), .widthSelect(widthSelect), .dmaReq(dmaReq), .dmaCycleEnd(dmaCycleEnd),
    .irqReq(irqReq), .irqVector(irqVector), .holdRequestOut(holdRequestOut), .busRequestN(busRequestN),
    .irqOutHigh(irqOutHigh), .irqOutLow(irqOutLow), .busOwnedInd(busOwnedInd), .vectorOut(vectorOut),
    .vectorOeN(vectorOeN), .dmaGo(dmaGo), .styleFirst(styleFirst), .wide16(wide16));
  host_arbiter_model host (.sys_clk(sys_clk), .modeSelect(modeSelect), .holdRequestOut(holdRequestOut),
    .busRequestN(busRequestN), .grantDelay(grantDelay), .holdAckIn(holdAckIn), .busGrantN(busGrantN));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait on the ownership pin, then judge it
  task automatic wait_own(logic v);
    for (int i = 0; i < 40 && busOwnedInd !== v; i++) tick(1);
    `CHK("busOwnedInd", v, busOwnedInd)
  endtask
  // last dma cycle ends with nothing left to move
  task automatic end_dma();
    @(posedge sys_clk);
    dmaReq <= 1'b0;
    dmaCycleEnd <= 1'b1;
    @(posedge sys_clk);
    dmaCycleEnd <= 1'b0;
    #1;
    `CHK("busOwnedInd", 1'b1, busOwnedInd)
    `CHK("dmaGo", 1'b0, dmaGo)
    tick(12);
  endtask
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic test_style(logic m, logic w);
    @(posedge sys_clk);
    modeSelect <= m;
    widthSelect <= w;
    tick(8);
    `CHK("styleFirst", m, styleFirst)
    `CHK("wide16", !(m && w), wide16)
  endtask
  task automatic test_dma();
    @(posedge sys_clk);
    dmaReq <= 1'b1;
    tick(2);
    `CHK("request", 1'b1, modeSelect ? holdRequestOut : !busRequestN)
    wait_own(1'b0);
    `CHK("dmaGo", 1'b1, dmaGo)
    end_dma();
  endtask
  task automatic test_busy();
    @(posedge sys_clk);
    busBusyN <= 1'b0;
    dmaReq <= 1'b1;
    tick(20);
    `CHK("busOwnedInd", 1'b1, busOwnedInd)
    @(posedge sys_clk);
    busBusyN <= 1'b1;
    wait_own(1'b0);
    end_dma();
  endtask
  // release mid-transfer: yield after the cycle, then win the bus again
  task automatic test_release();
    @(posedge sys_clk);
    dmaReq <= 1'b1;
    wait_own(1'b0);
    @(posedge sys_clk);
    busReleaseN <= 1'b0;
    tick(5);
    @(posedge sys_clk);
    dmaCycleEnd <= 1'b1;
    @(posedge sys_clk);
    dmaCycleEnd <= 1'b0;
    #1;
    `CHK("busOwnedInd", 1'b1, busOwnedInd)
    @(posedge sys_clk);
    busReleaseN <= 1'b1;
    wait_own(1'b0);
    end_dma();
  endtask
  task automatic test_irq();
    @(posedge sys_clk);
    irqReq <= 1'b1;
    tick(2);
    `CHK("irqActive", 1'b1, modeSelect ? irqOutHigh : !irqOutLow)
    @(posedge sys_clk);
    irqAckN <= 1'b0;
    tick(6);
    `CHK("vectorOeN", 1'b0, vectorOeN)
    `CHK("vectorOut", (modeSelect && widthSelect) ? {8'h00, irqVector[7:0]} : irqVector, vectorOut)
    @(posedge sys_clk);
    irqAckN <= 1'b1;
    irqReq <= 1'b0;
    tick(6);
    `CHK("vectorOeN", 1'b1, vectorOeN)
    `CHK("irqIdle", 1'b0, modeSelect ? irqOutHigh : !irqOutLow)
  endtask
  task automatic summarize();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // -------------------------------------------------------------
  // main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick(1);
    `CHK("resetPins", 5'h0E, {holdRequestOut, busRequestN, busOwnedInd, vectorOeN, dmaGo})
    `CHK("resetIrq", 4'h7, {irqOutHigh, irqOutLow, styleFirst, wide16})
    `CHK("resetVector", 16'h0000, vectorOut)
    test_style(1'b1, 1'b1);
    test_irq();
    test_dma();
    test_style(1'b1, 1'b0);
    grantDelay <= 4'h8;
    test_dma();
    test_busy();
    test_release();
    test_irq();
    test_style(1'b0, 1'b1);
    test_dma();
    test_release();
    test_irq();
    summarize();
  end
  // the whole run is well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
endmodule
bind host_bus_request_and_interrupt host_bus_sva chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .holdAckIn(holdAckIn), .busGrantN(busGrantN), .busBusyN(busBusyN), .dmaReq(dmaReq),
  .dmaCycleEnd(dmaCycleEnd), .irqReq(irqReq), .holdRequestOut(holdRequestOut), .busRequestN(busRequestN),
  .irqOutHigh(irqOutHigh), .irqOutLow(irqOutLow), .busOwnedInd(busOwnedInd), .vectorOeN(vectorOeN),
  .dmaGo(dmaGo), .styleFirst(styleFirst), .wide16(wide16));
`default_nettype wire
